// ### core/ifc_format_core.sv
// image format stage: combine, mirror, crop, substitute and pack pixels
//
// Chosen here: the AXI4-Lite register port and the address map.
`default_nettype none
module ifc_format_core
    import ifc_pkg::*;
#(
    parameter bit COLOUR_VARIANT = 1'b0
) (
    // clock and reset
    input  wire logic        SYS_CLK_I,
    input  wire logic        ARST_N_I,
    // axi4-lite write channels
    input  wire logic [7:0]  S_AXI_AWADDR_I,
    input  wire logic        S_AXI_AWVALID_I,
    output var  logic        S_AXI_AWREADY_O,
    input  wire logic [31:0] S_AXI_WDATA_I,
    input  wire logic [3:0]  S_AXI_WSTRB_I,
    input  wire logic        S_AXI_WVALID_I,
    output var  logic        S_AXI_WREADY_O,
    output var  logic [1:0]  S_AXI_BRESP_O,
    output var  logic        S_AXI_BVALID_O,
    input  wire logic        S_AXI_BREADY_I,
    // axi4-lite read channels
    input  wire logic [7:0]  S_AXI_ARADDR_I,
    input  wire logic        S_AXI_ARVALID_I,
    output var  logic        S_AXI_ARREADY_O,
    output var  logic [31:0] S_AXI_RDATA_O,
    output var  logic [1:0]  S_AXI_RRESP_O,
    output var  logic        S_AXI_RVALID_O,
    input  wire logic        S_AXI_RREADY_I,
    // sensor array read port
    output var  logic        SENS_REQ_O,
    output var  logic [9:0]  SENS_COL_O,
    output var  logic [9:0]  SENS_ROW_O,
    input  wire logic        SENS_ACK_I,
    input  wire logic [13:0] SENS_DATA_I,
    // pixel stream towards the host link
    output var  logic        PIX_VALID_O,
    output var  logic [15:0] PIX_DATA_O,
    output var  logic        PIX_SOF_O,
    output var  logic        PIX_EOL_O,
    output var  logic        PIX_EOF_O,
    // permission for auto exposure and gain loops
    output var  logic        AUTO_EN_O
);
    ifc_state_s s_r;
    ifc_state_s s_nxt;

    // zero factor is taken as 1 so a careless write cannot stall the walk
    function automatic logic [3:0] fac(input logic [3:0] f);
        return (f == 4'h0) ? 4'h1 : f;
    endfunction

    // step between used sensor cells: combining wins over decimation
    function automatic logic [3:0] step(input logic [3:0] b,
                                        input logic [3:0] d);
        return (fac(b) != 4'h1) ? fac(b) : fac(d);
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] dat,
                                          input logic [3:0]  strb,
                                          input logic [31:0] msk);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = dat[i*8 +: 8];
            end
        end
        return r & msk;
    endfunction

    // live settings decoded for register reads
    logic [3:0]  lv_fh;
    logic [3:0]  lv_fv;
    logic [9:0]  lv_lw;
    logic [9:0]  lv_lh;
    logic [3:0]  lv_depth;
    logic [13:0] lv_max;
    logic [15:0] lv_bright;
    // frame settings decoded from the shadow copy
    logic [3:0]  fh;
    logic [3:0]  fv;
    logic [3:0]  nh;
    logic [3:0]  nv;
    logic [9:0]  lw;
    logic [9:0]  lh;
    logic [3:0]  depth;
    logic [13:0] adc_max;
    ifc_src_e    src;
    logic [10:0] bx;
    logic [10:0] by;
    logic [9:0]  ubx;
    logic [9:0]  uby;
    logic [9:0]  scol;
    logic [9:0]  srow;
    logic [13:0] smp;
    logic        take;
    logic [17:0] acc_new;
    logic [13:0] sat;
    logic [31:0] wide;
    logic [15:0] fmt;
    logic        last_col;
    logic        last_row;
    logic [31:0] rd;
    logic        rd_err;
    logic        wr_err;

    // live decode: largest sizes use the factors only, never the crop
    always_comb begin
        lv_fh    = step(s_r.combine[3:0], s_r.combine[19:16]);
        lv_fv    = step(s_r.combine[11:8], s_r.combine[27:24]);
        lv_lw    = ARRAY_COLS / 10'(lv_fh);
        lv_lh    = ARRAY_ROWS / 10'(lv_fv);
        lv_depth = 4'd8 + {1'b0, s_r.ctrl[CTRL_RES_LSB +: 2], 1'b0};
        lv_max   = ADC_FULL >> (4'd14 - lv_depth);
        if (s_r.ctrl[CTRL_CORE_ON]) begin
            lv_bright = s_r.ctrl[CTRL_FMT16] ? 16'hffff : 16'h00ff;
        end else if (s_r.ctrl[CTRL_FMT16]) begin
            lv_bright = {2'h0, lv_max};
        end else begin
            lv_bright = {8'h00, lv_max[7:0]};
        end
    end

    // frame decode: sensor cell from output position, crop, then mirror
    always_comb begin
        fh      = step(s_r.sh_combine[3:0], s_r.sh_combine[19:16]);
        fv      = step(s_r.sh_combine[11:8], s_r.sh_combine[27:24]);
        nh      = fac(s_r.sh_combine[3:0]);
        nv      = fac(s_r.sh_combine[11:8]);
        lw      = ARRAY_COLS / 10'(fh);
        lh      = ARRAY_ROWS / 10'(fv);
        depth   = 4'd8 + {1'b0, s_r.sh_ctrl[CTRL_RES_LSB +: 2], 1'b0};
        adc_max = ADC_FULL >> (4'd14 - depth);
        src     = ifc_src_e'(s_r.sh_ctrl[CTRL_SRC_LSB +: 2]);
        bx      = {1'b0, s_r.sh_crop[9:0]} + {1'b0, s_r.ox};
        by      = {1'b0, s_r.sh_crop[25:16]} + {1'b0, s_r.oy};
        // crop coordinates live in the mirrored image, so undo it here
        ubx = s_r.sh_ctrl[CTRL_MIRROR_LR] ? 10'(lw - 10'd1 - bx[9:0])
                                          : bx[9:0];
        uby = s_r.sh_ctrl[CTRL_MIRROR_TB] ? 10'(lh - 10'd1 - by[9:0])
                                          : by[9:0];
        scol = 10'(ubx * fh) + {6'h0, s_r.kx};
        srow = 10'(uby * fv) + {6'h0, s_r.ky};
        // synthetic sources avoid the sensor port entirely
        if (src == SRC_PATTERN) begin
            smp = 14'(scol + srow) & adc_max;
        end else if (s_r.sh_insert[9:0] > scol
                     && s_r.sh_insert[25:16] > srow) begin
            smp = adc_max;
        end else begin
            smp = 14'h0000;
        end
        if (s_r.state == ST_WAIT) begin
            smp = SENS_DATA_I & adc_max;
        end
        acc_new  = s_r.acc + {4'h0, smp};
        sat      = (acc_new > {4'h0, adc_max}) ? adc_max : acc_new[13:0];
        last_col = ({6'h0, s_r.ox} + 16'd1) >= {6'h0, s_r.sh_size[9:0]};
        last_row = ({6'h0, s_r.oy} + 16'd1) >= {6'h0, s_r.sh_size[25:16]};
        // packing: scaled to full range with core on, raw otherwise
        if (s_r.sh_ctrl[CTRL_CORE_ON]) begin
            wide = ({18'h0, sat} << (5'd16 - 5'(depth)))
                 | ({18'h0, sat} >> (5'(depth) * 5'd2 - 5'd16));
            fmt  = s_r.sh_ctrl[CTRL_FMT16] ? wide[15:0]
                                           : {8'h00, wide[15:8]};
        end else begin
            wide = {18'h0, sat};
            fmt  = s_r.sh_ctrl[CTRL_FMT16] ? wide[15:0]
                                           : {8'h00, wide[7:0]};
        end
    end

    // register read mux; unmapped addresses answer slave error
    always_comb begin
        rd     = 32'h0;
        rd_err = 1'b0;
        case ({S_AXI_ARADDR_I[7:2], 2'b00})
            OFF_CTRL:    rd = s_r.ctrl;
            OFF_COMBINE: rd = s_r.combine;
            OFF_CROP:    rd = s_r.crop;
            OFF_SIZE:    rd = s_r.size;
            OFF_INSERT:  rd = s_r.insert;
            OFF_ARRAY:   rd = {6'h0, ARRAY_ROWS, 6'h0, ARRAY_COLS};
            OFF_LARGEST: rd = {6'h0, lv_lh, 6'h0, lv_lw};
            OFF_FORMAT: begin
                rd[4:0] = s_r.ctrl[CTRL_FMT16] ? 5'd16 : 5'd8;
                rd[9:8] = 2'b00;
                if (COLOUR_VARIANT) begin
                    rd[13:12] = {s_r.ctrl[CTRL_MIRROR_TB],
                                 s_r.ctrl[CTRL_MIRROR_LR]};
                end
            end
            OFF_RANGE:   rd = {lv_bright, 16'h0000};
            OFF_STATUS:  rd = {s_r.frame_cnt, 15'h0,
                               s_r.state != ST_IDLE};
            default:     rd_err = 1'b1;
        endcase
        case ({s_r.awaddr[7:2], 2'b00})
            OFF_CTRL, OFF_COMBINE, OFF_CROP, OFF_SIZE, OFF_INSERT,
            OFF_ARRAY, OFF_LARGEST, OFF_FORMAT, OFF_RANGE,
            OFF_STATUS: wr_err = 1'b0;
            default:    wr_err = 1'b1;
        endcase
    end

    // next state: bus slave, frame walk and pixel packing
    always_comb begin
        s_nxt           = s_r;
        s_nxt.pix_valid = 1'b0;
        s_nxt.pix_sof   = 1'b0;
        s_nxt.pix_eol   = 1'b0;
        s_nxt.pix_eof   = 1'b0;
        s_nxt.sens_req  = 1'b0;
        s_nxt.auto_en   = s_r.ctrl[CTRL_CORE_ON];
        take            = 1'b0;
        // write address and data are taken in either order
        if (S_AXI_AWVALID_I && s_r.awready) begin
            s_nxt.aw_ok  = 1'b1;
            s_nxt.awaddr = S_AXI_AWADDR_I;
        end
        if (S_AXI_WVALID_I && s_r.wready) begin
            s_nxt.w_ok  = 1'b1;
            s_nxt.wdata = S_AXI_WDATA_I;
            s_nxt.wstrb = S_AXI_WSTRB_I;
        end
        if (s_r.bvalid && S_AXI_BREADY_I) begin
            s_nxt.bvalid = 1'b0;
        end
        if (s_r.aw_ok && s_r.w_ok && !s_r.bvalid) begin
            s_nxt.aw_ok  = 1'b0;
            s_nxt.w_ok   = 1'b0;
            s_nxt.bvalid = 1'b1;
            s_nxt.bresp  = wr_err ? RESP_SLVERR : RESP_OKAY;
            case ({s_r.awaddr[7:2], 2'b00})
                OFF_CTRL: s_nxt.ctrl = merge(s_r.ctrl, s_r.wdata,
                                             s_r.wstrb, CTRL_WMASK);
                OFF_COMBINE: s_nxt.combine = merge(s_r.combine, s_r.wdata,
                                             s_r.wstrb, COMBINE_WMASK);
                OFF_CROP: s_nxt.crop = merge(s_r.crop, s_r.wdata,
                                             s_r.wstrb, GEOM_WMASK);
                OFF_SIZE: s_nxt.size = merge(s_r.size, s_r.wdata,
                                             s_r.wstrb, GEOM_WMASK);
                OFF_INSERT: s_nxt.insert = merge(s_r.insert, s_r.wdata,
                                             s_r.wstrb, GEOM_WMASK);
                default: ;
            endcase
        end
        if (s_r.rvalid && S_AXI_RREADY_I) begin
            s_nxt.rvalid = 1'b0;
        end
        if (S_AXI_ARVALID_I && s_r.arready) begin
            s_nxt.rvalid = 1'b1;
            s_nxt.rdata  = rd;
            s_nxt.rresp  = rd_err ? RESP_SLVERR : RESP_OKAY;
        end
        s_nxt.awready = !s_nxt.aw_ok && !s_nxt.bvalid;
        s_nxt.wready  = !s_nxt.w_ok && !s_nxt.bvalid;
        s_nxt.arready = !s_nxt.rvalid;
        // frame walk
        unique case (s_r.state)
            ST_IDLE: begin
                if (s_r.ctrl[CTRL_ENABLE]) begin
                    // settings are copied only here, between frames
                    s_nxt.sh_ctrl    = s_r.ctrl;
                    s_nxt.sh_combine = s_r.combine;
                    s_nxt.sh_crop    = s_r.crop;
                    s_nxt.sh_size    = s_r.size;
                    s_nxt.sh_insert  = s_r.insert;
                    s_nxt.ox         = 10'h000;
                    s_nxt.oy         = 10'h000;
                    s_nxt.kx         = 4'h0;
                    s_nxt.ky         = 4'h0;
                    s_nxt.acc        = ACC_ZERO;
                    s_nxt.sof_pend   = 1'b1;
                    s_nxt.state      = ST_FETCH;
                end
            end
            ST_FETCH: begin
                if (src == SRC_SENSOR || src == ifc_src_e'(2'd3)) begin
                    s_nxt.sens_req = 1'b1;
                    s_nxt.sens_col = scol;
                    s_nxt.sens_row = srow;
                    s_nxt.state    = ST_WAIT;
                end else begin
                    take = 1'b1;
                end
            end
            ST_WAIT: begin
                take = SENS_ACK_I;
            end
        endcase
        // sum the combine block, then emit one packed pixel
        if (take) begin
            s_nxt.state = ST_FETCH;
            if (s_r.kx + 4'h1 < nh) begin
                s_nxt.kx  = s_r.kx + 4'h1;
                s_nxt.acc = acc_new;
            end else if (s_r.ky + 4'h1 < nv) begin
                s_nxt.kx  = 4'h0;
                s_nxt.ky  = s_r.ky + 4'h1;
                s_nxt.acc = acc_new;
            end else begin
                s_nxt.kx        = 4'h0;
                s_nxt.ky        = 4'h0;
                s_nxt.acc       = ACC_ZERO;
                s_nxt.pix_valid = 1'b1;
                s_nxt.pix_data  = fmt;
                s_nxt.pix_sof   = s_r.sof_pend;
                s_nxt.sof_pend  = 1'b0;
                s_nxt.pix_eol   = last_col;
                s_nxt.pix_eof   = last_col && last_row;
                s_nxt.line_cnt  = last_col ? 10'h000
                                           : s_r.line_cnt + 10'h001;
                if (!last_col) begin
                    s_nxt.ox = s_r.ox + 10'h001;
                end else if (!last_row) begin
                    s_nxt.ox = 10'h000;
                    s_nxt.oy = s_r.oy + 10'h001;
                end else begin
                    s_nxt.state     = ST_IDLE;
                    s_nxt.frame_cnt = s_r.frame_cnt + 16'h0001;
                end
            end
        end
    end

    // single state register; reset loads constants only
    always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            s_r         <= '0;
            s_r.state   <= ST_IDLE;
            s_r.ctrl    <= CTRL_RST;
            s_r.combine <= COMBINE_RST;
            s_r.size    <= SIZE_RST;
            s_r.insert  <= SIZE_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    // outputs straight from the state register
    assign S_AXI_AWREADY_O = s_r.awready;
    assign S_AXI_WREADY_O  = s_r.wready;
    assign S_AXI_BVALID_O  = s_r.bvalid;
    assign S_AXI_BRESP_O   = s_r.bresp;
    assign S_AXI_ARREADY_O = s_r.arready;
    assign S_AXI_RVALID_O  = s_r.rvalid;
    assign S_AXI_RDATA_O   = s_r.rdata;
    assign S_AXI_RRESP_O   = s_r.rresp;
    assign SENS_REQ_O      = s_r.sens_req;
    assign SENS_COL_O      = s_r.sens_col;
    assign SENS_ROW_O      = s_r.sens_row;
    assign PIX_VALID_O     = s_r.pix_valid;
    assign PIX_DATA_O      = s_r.pix_data;
    assign PIX_SOF_O       = s_r.pix_sof;
    assign PIX_EOL_O       = s_r.pix_eol;
    assign PIX_EOF_O       = s_r.pix_eof;
    assign AUTO_EN_O       = s_r.auto_en;

    // checks on the walk, packing and register answers
    default clocking cb @(posedge SYS_CLK_I); endclocking
    default disable iff (!ARST_N_I);

    a_array_width: assert property (
        S_AXI_ARVALID_I && S_AXI_ARREADY_O
        && S_AXI_ARADDR_I == OFF_ARRAY
        |=> S_AXI_RVALID_O && S_AXI_RDATA_O[9:0] == 10'd728)
        else $error("array width not reported as 728");
    a_array_height: assert property (
        S_AXI_ARVALID_I && S_AXI_ARREADY_O
        && S_AXI_ARADDR_I == OFF_ARRAY
        |=> S_AXI_RDATA_O[25:16] == 10'd554)
        else $error("array height not reported as 554");
    a_shadow_hold: assert property (
        s_r.state != ST_IDLE && $past(s_r.state) != ST_IDLE
        |-> $stable(s_r.sh_size) && $stable(s_r.sh_ctrl)
            && $stable(s_r.sh_crop) && $stable(s_r.sh_combine))
        else $error("frame settings changed inside a frame");
    a_auto_gate: assert property (
        ##1 AUTO_EN_O == $past(s_r.ctrl[CTRL_CORE_ON]))
        else $error("auto permission does not follow core enable");
    a_raw_lsb: assert property (
        PIX_VALID_O && !s_r.sh_ctrl[CTRL_CORE_ON]
        |-> PIX_DATA_O[15:14] == 2'b00)
        else $error("raw sample not lsb aligned");
    a_byte_fmt: assert property (
        PIX_VALID_O && !s_r.sh_ctrl[CTRL_FMT16]
        |-> PIX_DATA_O[15:8] == 8'h00)
        else $error("byte format carries upper bits");
    a_line_width: assert property (
        take && s_r.kx + 4'h1 >= nh && s_r.ky + 4'h1 >= nv && last_col
        |-> s_r.line_cnt + 10'h001 == s_r.sh_size[9:0]
            || s_r.sh_size[9:0] == 10'h000)
        else $error("line length differs from programmed width");
    a_decim_gate: assert property (
        s_r.state == ST_FETCH && fac(s_r.sh_combine[3:0]) != 4'h1
        |-> fh == fac(s_r.sh_combine[3:0]))
        else $error("decimation active while combining");
    a_mirror_col: assert property (
        s_r.state == ST_FETCH && src == SRC_SENSOR && fh == 4'h1
        && s_r.sh_ctrl[CTRL_MIRROR_LR] && bx < {1'b0, lw}
        |=> SENS_REQ_O && SENS_COL_O == $past(lw - 10'd1 - bx[9:0]))
        else $error("mirrored column address wrong");
    a_write_resp: assert property (
        s_r.aw_ok && s_r.w_ok && !s_r.bvalid |=> S_AXI_BVALID_O)
        else $error("write response missing");

    c_frame_end: cover property (PIX_EOF_O);
    c_mirror_frame: cover property (PIX_EOF_O
        && s_r.sh_ctrl[CTRL_MIRROR_LR] && s_r.sh_ctrl[CTRL_MIRROR_TB]);
    c_binned_pix: cover property (PIX_VALID_O && nh > 4'h1 && nv > 4'h1);
    c_pattern_pix: cover property (PIX_VALID_O && src == SRC_PATTERN);
endmodule
`default_nettype wire

// ### pkg/ifc_pkg.sv
// package: register map, field layout, reset values and state of the format stage
`default_nettype none
package ifc_pkg;
    // register byte offsets on the AXI4-Lite slave
    localparam logic [7:0] OFF_CTRL    = 8'h00;
    localparam logic [7:0] OFF_COMBINE = 8'h04;
    localparam logic [7:0] OFF_CROP    = 8'h08;
    localparam logic [7:0] OFF_SIZE    = 8'h0c;
    localparam logic [7:0] OFF_INSERT  = 8'h10;
    localparam logic [7:0] OFF_ARRAY   = 8'h14;
    localparam logic [7:0] OFF_LARGEST = 8'h18;
    localparam logic [7:0] OFF_FORMAT  = 8'h1c;
    localparam logic [7:0] OFF_RANGE   = 8'h20;
    localparam logic [7:0] OFF_STATUS  = 8'h24;
    // control word bit positions
    localparam int CTRL_ENABLE    = 0;
    localparam int CTRL_MIRROR_LR = 1;
    localparam int CTRL_MIRROR_TB = 2;
    localparam int CTRL_CORE_ON   = 3;
    localparam int CTRL_FMT16     = 4;
    localparam int CTRL_SRC_LSB   = 5;
    localparam int CTRL_RES_LSB   = 8;
    // writable bits; the rest read as zero
    localparam logic [31:0] CTRL_WMASK    = 32'h0000_037f;
    localparam logic [31:0] COMBINE_WMASK = 32'h0f0f_0f0f;
    localparam logic [31:0] GEOM_WMASK    = 32'h03ff_03ff;
    // values after reset
    localparam logic [31:0] CTRL_RST    = 32'h0000_0300;
    localparam logic [31:0] COMBINE_RST = 32'h0101_0101;
    localparam logic [31:0] SIZE_RST    = 32'h022a_02d8;
    // fixed array geometry, datapath widths and AXI response codes
    localparam logic [9:0]  ARRAY_COLS = 10'd728;
    localparam logic [9:0]  ARRAY_ROWS = 10'd554;
    localparam logic [13:0] ADC_FULL   = 14'h3fff;
    localparam logic [17:0] ACC_ZERO   = 18'h00000;
    localparam logic [1:0]  RESP_OKAY   = 2'b00;
    localparam logic [1:0]  RESP_SLVERR = 2'b10;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_FETCH = 3'b010,
        ST_WAIT  = 3'b100
    } ifc_state_e;

    typedef enum logic [1:0] {
        SRC_SENSOR   = 2'd0,
        SRC_PATTERN  = 2'd1,
        SRC_INSERTED = 2'd2
    } ifc_src_e;

    typedef struct packed {
        ifc_state_e  state;
        logic        aw_ok;
        logic        w_ok;
        logic [7:0]  awaddr;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic [31:0] ctrl;
        logic [31:0] combine;
        logic [31:0] crop;
        logic [31:0] size;
        logic [31:0] insert;
        logic [31:0] sh_ctrl;
        logic [31:0] sh_combine;
        logic [31:0] sh_crop;
        logic [31:0] sh_size;
        logic [31:0] sh_insert;
        logic [9:0]  ox;
        logic [9:0]  oy;
        logic [3:0]  kx;
        logic [3:0]  ky;
        logic [17:0] acc;
        logic        sof_pend;
        logic        pix_valid;
        logic [15:0] pix_data;
        logic        pix_sof;
        logic        pix_eol;
        logic        pix_eof;
        logic        sens_req;
        logic [9:0]  sens_col;
        logic [9:0]  sens_row;
        logic        auto_en;
        logic [15:0] frame_cnt;
        logic [9:0]  line_cnt;
    } ifc_state_s;
endpackage
`default_nettype wire

// ### bench/ifc_sensor_model.sv
// sensor array model: answers each cell read after a settable delay
`default_nettype none
module ifc_sensor_model (
    // read request from the format stage
    input  wire logic        clk_i,
    input  wire logic        req_i,
    input  wire logic [9:0]  col_i,
    input  wire logic [9:0]  row_i,
    input  wire logic [3:0]  delay_i,
    // answer
    output var  logic        ack_o,
    output var  logic [13:0] data_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0]  cnt_r  = 4'h0;
    logic        busy_r = 1'h0;
    logic [13:0] cell_r = 14'h0000;
    initial ack_o = 1'h0;
    // data only means something with ack; stale value is inverted on purpose
    always @(posedge clk_i) begin
        ack_o <= 1'h0;
        data_o <= ~cell_r;
        if (req_i) begin
            busy_r <= 1'h1;
            cnt_r <= delay_i;
            cell_r <= {row_i[3:0], col_i};
        end else if (busy_r && cnt_r == 4'h0) begin
            busy_r <= 1'h0;
            ack_o <= 1'h1;
            data_o <= cell_r;
        end else if (busy_r) begin
            cnt_r <= cnt_r - 4'h1;
        end
    end
endmodule
`default_nettype wire

// ### bench/testbench.sv
// self-checking bench for the image format stage
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import ifc_pkg::*;
    logic SYS_CLK_I = 1'h0, ARST_N_I = 1'h0, S_AXI_AWVALID_I = 1'h0;
    logic S_AXI_WVALID_I = 1'h0, S_AXI_ARVALID_I = 1'h0;
    logic S_AXI_BREADY_I = 1'h1, S_AXI_RREADY_I = 1'h1;
    logic S_AXI_AWREADY_O, S_AXI_WREADY_O, S_AXI_BVALID_O, S_AXI_ARREADY_O;
    logic S_AXI_RVALID_O, SENS_REQ_O, SENS_ACK_I, PIX_VALID_O, PIX_SOF_O;
    logic PIX_EOL_O, PIX_EOF_O, AUTO_EN_O;
    logic [7:0]  S_AXI_AWADDR_I = 8'h00, S_AXI_ARADDR_I = 8'h00;
    logic [31:0] S_AXI_WDATA_I = 32'h0, S_AXI_RDATA_O, d;
    logic [3:0]  S_AXI_WSTRB_I = 4'hf, dly = 4'h3;
    logic [1:0]  S_AXI_BRESP_O, S_AXI_RRESP_O, r;
    logic [9:0]  SENS_COL_O, SENS_ROW_O;
    logic [13:0] SENS_DATA_I;
    logic [15:0] PIX_DATA_O;
    int num_errors = 0, comparisons = 0, cycles = 0;
    always #10 SYS_CLK_I = ~SYS_CLK_I;
    ifc_format_core DUT (.SYS_CLK_I, .ARST_N_I, .S_AXI_AWADDR_I,
        .S_AXI_AWVALID_I, .S_AXI_AWREADY_O, .S_AXI_WDATA_I, .S_AXI_WSTRB_I,
        .S_AXI_WVALID_I, .S_AXI_WREADY_O, .S_AXI_BRESP_O, .S_AXI_BVALID_O,
        .S_AXI_BREADY_I, .S_AXI_ARADDR_I, .S_AXI_ARVALID_I, .S_AXI_ARREADY_O,
        .S_AXI_RDATA_O, .S_AXI_RRESP_O, .S_AXI_RVALID_O, .S_AXI_RREADY_I,
        .SENS_REQ_O, .SENS_COL_O, .SENS_ROW_O, .SENS_ACK_I, .SENS_DATA_I,
        .PIX_VALID_O, .PIX_DATA_O, .PIX_SOF_O, .PIX_EOL_O, .PIX_EOF_O,
        .AUTO_EN_O);
    ifc_sensor_model sensor (.clk_i(SYS_CLK_I), .req_i(SENS_REQ_O),
        .col_i(SENS_COL_O), .row_i(SENS_ROW_O), .delay_i(dly),
        .ack_o(SENS_ACK_I), .data_o(SENS_DATA_I));
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // a hang is cut short here and counted as a mismatch
    always @(posedge SYS_CLK_I) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            print_verdict();
        end
    end
    task automatic chk(input string n, input logic [31:0] s, e);
        comparisons++;
        if (s !== e) begin
            num_errors++;
            $display("BAD %s exp %h seen %h", n, e, s);
        end
    endtask
    // address and data offered together; each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge SYS_CLK_I);
        S_AXI_AWADDR_I <= a;
        S_AXI_WDATA_I <= v;
        S_AXI_AWVALID_I <= 1'h1;
        S_AXI_WVALID_I <= 1'h1;
        fork
            begin do @(posedge SYS_CLK_I); while (!S_AXI_AWREADY_O);
                S_AXI_AWVALID_I <= 1'h0; end
            begin do @(posedge SYS_CLK_I); while (!S_AXI_WREADY_O);
                S_AXI_WVALID_I <= 1'h0; end
        join
        do @(posedge SYS_CLK_I); while (S_AXI_BVALID_O !== 1'h1);
        r = S_AXI_BRESP_O;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge SYS_CLK_I);
        S_AXI_ARADDR_I <= a;
        S_AXI_ARVALID_I <= 1'h1;
        do @(posedge SYS_CLK_I); while (!S_AXI_ARREADY_O);
        S_AXI_ARVALID_I <= 1'h0;
        do @(posedge SYS_CLK_I); while (S_AXI_RVALID_O !== 1'h1);
        d = S_AXI_RDATA_O;
        r = S_AXI_RRESP_O;
    endtask
    // fixed geometry, format and range words after reset
    task automatic t_fixed();
        rd(OFF_ARRAY);
        chk("array", d, 32'h022a_02d8);
        rd(OFF_FORMAT);
        chk("format", d, 32'h0000_0008);
        rd(OFF_RANGE);
        chk("darkest", {16'h0, d[15:0]}, 32'h0);
        chk("brightest", {16'h0, d[31:16]}, 32'h0000_00ff);
        rd(8'h40);
        chk("unmapped", {30'h0, r}, {30'h0, RESP_SLVERR});
    endtask
    // crop inside the largest window; largest must only follow the factors
    task automatic t_largest();
        wr(OFF_CROP, 32'h0001_0004);
        // column decimation 4 must be ignored while columns are combined
        wr(OFF_COMBINE, 32'h0104_0302);
        rd(OFF_LARGEST);
        chk("largest", d, 32'h00b8_016c);
        wr(OFF_COMBINE, COMBINE_RST);
        wr(OFF_CROP, 32'h0);
    endtask
    task automatic pix(input logic [15:0] e, input logic eof);
        do @(posedge SYS_CLK_I); while (PIX_VALID_O !== 1'h1);
        chk("pixel", {16'h0, PIX_DATA_O}, {16'h0, e});
        chk("eof", {31'h0, PIX_EOF_O}, {31'h0, eof});
    endtask
    // 2x1 frame, mirrored, 16-bit, core off: raw cells zero extended
    task automatic t_frame();
        wr(OFF_SIZE, 32'h0001_0002);
        wr(OFF_CTRL, 32'h0000_0313);
        pix(16'h02d7, 1'h0);
        pix(16'h02d6, 1'h1);
        chk("auto off", {31'h0, AUTO_EN_O}, 32'h0);
        wr(OFF_CTRL, 32'h0000_0008);
        repeat (2) @(posedge SYS_CLK_I);
        chk("auto on", {31'h0, AUTO_EN_O}, 32'h1);
    endtask
    // pattern source, core on, 16-bit, 8-bit depth, column pairs summed,
    // top-bottom mirror under a crop window; cells read (col+row)&0xff
    task automatic t_pattern();
        wr(OFF_CROP, 32'h0005_0003);
        wr(OFF_COMBINE, 32'h0101_0102);
        // the frame started back to back has ended by now: two frames
        rd(OFF_STATUS);
        chk("status", d, 32'h0002_0000);
        wr(OFF_CTRL, 32'h0000_003d);
        pix(16'h5555, 1'h0);
        pix(16'h5959, 1'h1);
        rd(OFF_FORMAT);
        chk("format16", d, 32'h0000_0010);
        rd(OFF_RANGE);
        chk("brightest16", {16'h0, d[31:16]}, 32'h0000_ffff);
    endtask
    initial begin
        repeat (12) @(posedge SYS_CLK_I);
        ARST_N_I <= 1'h1;
        t_fixed();
        t_largest();
        t_frame();
        t_pattern();
        print_verdict();
    end
endmodule
`default_nettype wire
